// >>> hdl/exc_defines.vh
// Constants for the exception entry unit: vectors, modes, PSR fields,
// condition codes and entry timing.
// Assumes a 26-bit address space and the combined 32-bit PC/PSR word.
`ifndef EXC_DEFINES_VH
`define EXC_DEFINES_VH
`define VEC_RESET 26'h0000000
`define VEC_UNDEF 26'h0000004
`define VEC_SWI 26'h0000008
`define VEC_PABORT 26'h000000C
`define VEC_DABORT 26'h0000010
`define VEC_ADDREXC 26'h0000014
`define VEC_IRQ 26'h0000018
`define VEC_FIQ 26'h000001C
`define MODE_USR 2'h0
`define MODE_FIQ 2'h1
`define MODE_IRQ 2'h2
`define MODE_SVC 2'h3
`define PSR_N 31
`define PSR_Z 30
`define PSR_C 29
`define PSR_V 28
`define PSR_I 27
`define PSR_F 26
`define PC_HI 25
`define PC_LO 2
`define ADDR_TOP_HI 31
`define ADDR_TOP_LO 26
`define ADJ_PABORT 32'h00000004
`define ADJ_DABORT 32'h00000008
`define ADJ_IRQ 32'h00000004
`define ADJ_FIQ 32'h00000004
`define COND_EQ 4'h0
`define COND_NE 4'h1
`define COND_CS 4'h2
`define COND_CC 4'h3
`define COND_MI 4'h4
`define COND_PL 4'h5
`define COND_VS 4'h6
`define COND_VC 4'h7
`define COND_HI 4'h8
`define COND_LS 4'h9
`define COND_GE 4'hA
`define COND_LT 4'hB
`define COND_GT 4'hC
`define COND_LE 4'hD
`define COND_AL 4'hE
`define COND_NV 4'hF
`define EXC_ENTRY_CYC 2'h3
`define FIQ_ENTRY_CYC 2'h2
`define NORM_ENTRY_CYC 2'h2
`define LDM_MAX_CYC 5'h12
`endif

// >>> hdl/req_sync.v
// Three-stage synchroniser for an asynchronous active-low request pin.
// Assumes the pin may change at any time relative to sys_clk_in.
`timescale 1ns/1ps
module req_sync (
  input wire sys_clk_in,
  input wire rstn_in,
  input wire req_n_in,
  output reg req_active_out
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  // Stage one feeds only stage two; a change counts once two and three agree.
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      req_active_out <= 1'b0;
    end else begin
      s1_q <= req_n_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        req_active_out <= ~s3_q;
      end
    end
  end
endmodule // req_sync

// >>> hdl/cond_check.v
// Condition field evaluator against the N, Z, C and V flags.
// Assumes flags are those left by the preceding instruction.
`timescale 1ns/1ps
`include "exc_defines.vh"
module cond_check (
  input wire [3:0] cond_in,
  input wire [3:0] nzcv_in,
  output reg pass_out
);
  wire n = nzcv_in[3];
  wire z = nzcv_in[2];
  wire c = nzcv_in[1];
  wire v = nzcv_in[0];
  // Pure decode so the core can gate execution in the same cycle.
  always @* begin
    case (cond_in)
      `COND_EQ: pass_out = z;
      `COND_NE: pass_out = ~z;
      `COND_CS: pass_out = c;
      `COND_CC: pass_out = ~c;
      `COND_MI: pass_out = n;
      `COND_PL: pass_out = ~n;
      `COND_VS: pass_out = v;
      `COND_VC: pass_out = ~v;
      `COND_HI: pass_out = c & ~z;
      `COND_LS: pass_out = ~c | z;
      `COND_GE: pass_out = (n == v);
      `COND_LT: pass_out = (n != v);
      `COND_GT: pass_out = ~z & (n == v);
      `COND_LE: pass_out = z | (n != v);
      `COND_AL: pass_out = 1'b1;
      default: pass_out = 1'b0;
    endcase
  end
endmodule // cond_check

// >>> hdl/exc_entry.v
// Exception entry and priority sequencer of a 26-bit-address core.
// Assumes the core presents one retiring instruction per end_of_instr_in
// pulse and applies the PC, mode and link values this unit drives.
//
// What this block does
// - After reset save PC/PSR to supervisor link, supervisor, F and I set.
// - Undefined trap: save to supervisor link, supervisor, set I, vector 4.
// - Software interrupt: save to supervisor link, supervisor, set I, 8.
// - Abort: supervisor entry, set I; data to 10h, prefetch to 0Ch.
// - Abort link value: minus 4 retries prefetch, minus 8 retries data.
// - Address exception: store becomes load, finish, supervisor entry, 14h.
// - Normal interrupt: interrupt-mode link, set I, 18h, return link minus 4.
// - Fast interrupt: fast-mode link, set F and I, vector 1Ch.
// - Offer undefined instructions to coprocessors; wait on busy; else trap.
// - While reset is high abandon the instruction and run no-operations.
// - Priority: reset, address/data abort, fast, normal, prefetch, undef.
// - Ignore the abort input when the data address is illegal.
// - Address or data abort with enabled fast interrupt: take both entries.
// - Request synchroniser delays recognition by at most 4 cycles.
// - Data abort and address exception entry three cycles, prefetch abort and fast entry two, load multiple up to 18.
// - Least request to vector load delay is just over 6 cycles.
// - Execute only if condition holds on flags left by prior instruction.
// - Always executes regardless; never is a one-cycle no-operation.
// - Condition 0000 executes only when the zero flag is set.
// - Sample synchronised requests at each instruction end when enabled.
// - Address exception if any of top six bits set; skip branches, first word only.
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "exc_defines.vh"
module exc_entry #(
  parameter LDM_MAX = `LDM_MAX_CYC
) (
  input wire sys_clk_in,
  input wire rstn_in,
  input wire reset_input_in,
  input wire fast_interrupt_request_n_in,
  input wire irq_request_n_in,
  input wire abort_input_in,
  input wire end_of_instr_in,
  input wire [31:0] pc_psr_register_in,
  input wire [3:0] cond_in,
  input wire undef_instr_in,
  input wire cop_instr_in,
  input wire software_interrupt_instruction_in,
  input wire prefetch_abort_flag_in,
  input wire data_access_in,
  input wire store_in,
  input wire branch_in,
  input wire block_later_word_in,
  input wire [31:0] data_addr_in,
  input wire cop_accept_in,
  input wire cop_busy_in,
  output reg exec_enable_out,
  output reg force_load_out,
  output reg stall_out,
  output reg cop_offer_out,
  output reg entry_busy_out,
  output reg pc_load_out,
  output reg [25:0] pc_value_out,
  output reg link_write_out,
  output reg [1:0] link_bank_out,
  output reg [31:0] link_register_out,
  output reg mode_bit_high_out,
  output reg mode_bit_low_out,
  output reg int_disable_out,
  output reg fiq_disable_out
);
  localparam ST_RESET = 3'h0;
  localparam ST_RUN = 3'h1;
  localparam ST_ENTRY = 3'h2;
  localparam ST_COPWAIT = 3'h3;

  localparam EXC_NONE = 3'h0;
  localparam EXC_ADDR = 3'h1;
  localparam EXC_DABT = 3'h2;
  localparam EXC_FIQ = 3'h3;
  localparam EXC_IRQ = 3'h4;
  localparam EXC_PABT = 3'h5;
  localparam EXC_UND = 3'h6;
  localparam EXC_SWI = 3'h7;

  // Vector address per exception kind; used by both entry paths.
  function [25:0] vec_of;
    input [2:0] k;
    begin
      case (k)
        EXC_ADDR: vec_of = `VEC_ADDREXC;
        EXC_DABT: vec_of = `VEC_DABORT;
        EXC_FIQ: vec_of = `VEC_FIQ;
        EXC_IRQ: vec_of = `VEC_IRQ;
        EXC_PABT: vec_of = `VEC_PABORT;
        EXC_UND: vec_of = `VEC_UNDEF;
        EXC_SWI: vec_of = `VEC_SWI;
        default: vec_of = `VEC_RESET;
      endcase
    end
  endfunction

  // Mode entered per exception kind.
  function [1:0] mode_of;
    input [2:0] k;
    begin
      case (k)
        EXC_FIQ: mode_of = `MODE_FIQ;
        EXC_IRQ: mode_of = `MODE_IRQ;
        default: mode_of = `MODE_SVC;
      endcase
    end
  endfunction

  // Entry length in cycles per kind.
  function [1:0] len_of;
    input [2:0] k;
    begin
      case (k)
        EXC_ADDR: len_of = `EXC_ENTRY_CYC;
        EXC_DABT: len_of = `EXC_ENTRY_CYC;
        EXC_FIQ: len_of = `FIQ_ENTRY_CYC;
        default: len_of = `NORM_ENTRY_CYC;
      endcase
    end
  endfunction

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [2:0] kind_q;
  reg [1:0] cnt_q;
  reg fiq_chain_q;
  reg reset_s1_q;
  reg reset_s2_q;
  reg reset_s3_q;
  reg reset_level_q;
  reg dabt_pend_q;
  reg addr_pend_q;
  wire fiq_sync;
  wire irq_sync;
  wire cond_pass;
  wire addr_illegal;
  wire [31:0] saved_word;
  wire [1:0] entry_mode;

  req_sync u_fiq_sync (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .req_n_in(fast_interrupt_request_n_in),
    .req_active_out(fiq_sync)
  );

  req_sync u_irq_sync (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .req_n_in(irq_request_n_in),
    .req_active_out(irq_sync)
  );

  cond_check u_cond (
    .cond_in(cond_in),
    .nzcv_in(pc_psr_register_in[`PSR_N:`PSR_V]),
    .pass_out(cond_pass)
  );

  // The reset pin is asynchronous to the core; filter it like a request.
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reset_s1_q <= 1'b1;
      reset_s2_q <= 1'b1;
      reset_s3_q <= 1'b1;
      reset_level_q <= 1'b1;
    end else begin
      reset_s1_q <= reset_input_in;
      reset_s2_q <= reset_s1_q;
      reset_s3_q <= reset_s2_q;
      if (reset_s2_q == reset_s3_q) begin
        reset_level_q <= reset_s3_q;
      end
    end
  end

  // Top six bits of a computed data address; branches and later block
  // words are never checked.
  assign addr_illegal = data_access_in & ~branch_in & ~block_later_word_in &
                        (|data_addr_in[`ADDR_TOP_HI:`ADDR_TOP_LO]);

  // Abort is masked when the address itself is illegal, so the two never
  // coexist.
  wire dabt_now = data_access_in & abort_input_in & ~addr_illegal;

  // A fault seen in the retiring cycle itself must not slip over to the
  // next instruction end, so the live test joins the held flag.
  wire addr_fault = addr_pend_q | addr_illegal;
  wire dabt_fault = dabt_pend_q | dabt_now;

  // Condition-gated traps: a failed condition makes the instruction inert.
  wire undef_now = cond_pass & (undef_instr_in | cop_instr_in);
  wire swi_now = cond_pass & software_interrupt_instruction_in;
  wire fiq_ok = fiq_sync & ~pc_psr_register_in[`PSR_F];
  wire irq_ok = irq_sync & ~pc_psr_register_in[`PSR_I];

  // Fixed priority pick among pending exceptions at instruction end.
  reg [2:0] pick;
  always @* begin
    if (addr_fault) begin
      pick = EXC_ADDR;
    end else if (dabt_fault) begin
      pick = EXC_DABT;
    end else if (fiq_ok) begin
      pick = EXC_FIQ;
    end else if (irq_ok) begin
      pick = EXC_IRQ;
    end else if (prefetch_abort_flag_in) begin
      pick = EXC_PABT;
    end else if (swi_now) begin
      pick = EXC_SWI;
    end else begin
      pick = EXC_NONE;
    end
  end

  // Link value: PC already two words ahead, so retry offsets fall out of
  // the saved word directly.
  assign saved_word = pc_psr_register_in;

  // Mode of the entry being committed, split onto the two mode bits.
  assign entry_mode = mode_of(kind_q);

  // Next-state logic for the sequencer.
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RESET: begin
        if (!reset_level_q) begin
          state_d = ST_ENTRY;
        end
      end
      ST_RUN: begin
        if (end_of_instr_in && pick != EXC_NONE) begin
          state_d = ST_ENTRY;
        end else if (undef_now && !addr_fault && !dabt_fault &&
                     !fiq_ok && !irq_ok && !prefetch_abort_flag_in) begin
          state_d = ST_COPWAIT;
        end
      end
      ST_COPWAIT: begin
        if (!cop_busy_in) begin
          state_d = cop_accept_in ? ST_RUN : ST_ENTRY;
        end
      end
      ST_ENTRY: begin
        if (cnt_q == 2'h1 && !fiq_chain_q) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_RESET;
    endcase
    if (reset_level_q) begin
      state_d = ST_RESET;
    end
  end

  // Sequencer registers and outputs; all outputs are flip-flops.
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= ST_RESET;
      kind_q <= EXC_NONE;
      cnt_q <= 2'h0;
      fiq_chain_q <= 1'b0;
      dabt_pend_q <= 1'b0;
      addr_pend_q <= 1'b0;
      exec_enable_out <= 1'b0;
      force_load_out <= 1'b0;
      stall_out <= 1'b1;
      cop_offer_out <= 1'b0;
      entry_busy_out <= 1'b0;
      pc_load_out <= 1'b0;
      pc_value_out <= `VEC_RESET;
      link_write_out <= 1'b0;
      link_bank_out <= `MODE_SVC;
      link_register_out <= 32'h00000000;
      mode_bit_high_out <= 1'b1;
      mode_bit_low_out <= 1'b1;
      int_disable_out <= 1'b1;
      fiq_disable_out <= 1'b1;
    end else begin
      state_q <= state_d;
      pc_load_out <= 1'b0;
      link_write_out <= 1'b0;
      force_load_out <= 1'b0;
      cop_offer_out <= 1'b0;
      exec_enable_out <= (state_d == ST_RUN) & cond_pass;
      stall_out <= (state_d != ST_RUN);
      entry_busy_out <= (state_d == ST_ENTRY);
      // Data faults of the running instruction are held to its end.
      if (state_q == ST_RUN) begin
        if (addr_illegal) begin
          addr_pend_q <= 1'b1;
          force_load_out <= store_in;
        end
        if (dabt_now) begin
          dabt_pend_q <= 1'b1;
        end
      end
      case (state_q)
        ST_RESET: begin
          exec_enable_out <= 1'b0;
          addr_pend_q <= 1'b0;
          dabt_pend_q <= 1'b0;
          fiq_chain_q <= 1'b0;
          kind_q <= EXC_NONE;
          cnt_q <= `NORM_ENTRY_CYC;
        end
        ST_RUN: begin
          if (state_d == ST_ENTRY) begin
            kind_q <= pick;
            cnt_q <= len_of(pick);
            // Enabled fast request rides behind a transfer-fault entry.
            fiq_chain_q <= (pick == EXC_ADDR || pick == EXC_DABT) &&
                           fiq_ok;
          end
          if (state_d == ST_COPWAIT) begin
            cop_offer_out <= 1'b1;
          end
        end
        ST_COPWAIT: begin
          cop_offer_out <= 1'b1;
          if (state_d == ST_ENTRY) begin
            kind_q <= EXC_UND;
            cnt_q <= len_of(EXC_UND);
          end
        end
        ST_ENTRY: begin
          cnt_q <= cnt_q - 2'h1;
          if (cnt_q == 2'h1) begin
            // Last entry cycle: commit link, mode, masks and vector.
            pc_load_out <= 1'b1;
            link_write_out <= 1'b1;
            link_register_out <= saved_word;
            pc_value_out <= vec_of(kind_q);
            link_bank_out <= mode_of(kind_q);
            mode_bit_high_out <= entry_mode[1];
            mode_bit_low_out <= entry_mode[0];
            int_disable_out <= 1'b1;
            if (kind_q == EXC_FIQ || kind_q == EXC_NONE) begin
              fiq_disable_out <= 1'b1;
            end
            if (kind_q == EXC_ADDR) begin
              addr_pend_q <= 1'b0;
            end
            if (kind_q == EXC_DABT) begin
              dabt_pend_q <= 1'b0;
            end
            if (fiq_chain_q) begin
              fiq_chain_q <= 1'b0;
              kind_q <= EXC_FIQ;
              cnt_q <= `FIQ_ENTRY_CYC;
            end
          end
        end
        default: begin
          kind_q <= EXC_NONE;
        end
      endcase
    end
  end
endmodule // exc_entry

// >>> sim/exc_entry_assertions.sv
// Checker for the exception entry unit, bound to its top module.
// Assumes one clock domain and a bench that keeps the hand-over contract.
`timescale 1ns/1ps
`include "exc_defines.vh"
module exc_entry_chk #(
  parameter LDM_MAX = 18
) (
  input wire sys_clk_in,
  input wire rstn_in,
  input wire reset_input_in,
  input wire fast_interrupt_request_n_in,
  input wire irq_request_n_in,
  input wire end_of_instr_in,
  input wire [31:0] pc_psr_register_in,
  input wire [3:0] cond_in,
  input wire data_access_in,
  input wire branch_in,
  input wire block_later_word_in,
  input wire store_in,
  input wire [31:0] data_addr_in,
  input wire cop_busy_in,
  input wire exec_enable_out,
  input wire stall_out,
  input wire cop_offer_out,
  input wire entry_busy_out,
  input wire force_load_out,
  input wire pc_load_out,
  input wire [25:0] pc_value_out,
  input wire link_write_out,
  input wire [1:0] link_bank_out,
  input wire mode_bit_high_out,
  input wire mode_bit_low_out,
  input wire int_disable_out,
  input wire fiq_disable_out
);
  // Mode pair and the illegal-address test, shared by several properties.
  wire [1:0] mode = {mode_bit_high_out, mode_bit_low_out};
  wire bad_addr = |data_addr_in[31:26];
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);

  // A held reset pin must keep the core on no-operations.
  a_reset_noop: assert property (reset_input_in [*6] |->
    stall_out && !exec_enable_out && !pc_load_out)
    else $error("execution while reset pin high");
  a_reset_entry: assert property (pc_load_out && pc_value_out == `VEC_RESET
    |-> link_write_out && link_bank_out == `MODE_SVC && mode == `MODE_SVC
    && int_disable_out && fiq_disable_out)
    else $error("reset entry state wrong");
  a_fiq_entry: assert property (pc_load_out && pc_value_out == `VEC_FIQ
    |-> link_write_out && link_bank_out == `MODE_FIQ && mode == `MODE_FIQ
    && int_disable_out && fiq_disable_out)
    else $error("fast entry state wrong");
  a_irq_entry: assert property (pc_load_out && pc_value_out == `VEC_IRQ
    |-> link_write_out && link_bank_out == `MODE_IRQ && mode == `MODE_IRQ
    && int_disable_out)
    else $error("normal interrupt entry state wrong");
  a_svc_entry: assert property (pc_load_out && pc_value_out inside
    {`VEC_UNDEF, `VEC_SWI, `VEC_PABORT, `VEC_DABORT, `VEC_ADDREXC}
    |-> link_write_out && link_bank_out == `MODE_SVC && mode == `MODE_SVC
    && int_disable_out)
    else $error("supervisor entry state wrong");
  // The synchroniser cannot hand a fast request over in under 3 cycles.
  a_min_latency: assert property ($fell(fast_interrupt_request_n_in)
    |-> !pc_load_out [*3])
    else $error("fast entry too soon");
  a_irq_needed: assert property (irq_request_n_in [*8]
    |-> !(pc_load_out && pc_value_out == `VEC_IRQ))
    else $error("normal interrupt entry without request");
  // An illegal data address wins over abort and takes three cycles.
  a_addr_exc: assert property (end_of_instr_in && !stall_out && bad_addr
    && data_access_in && !branch_in && !block_later_word_in
    && !reset_input_in |-> ##4 pc_load_out
    && pc_value_out == `VEC_ADDREXC)
    else $error("address exception not taken");
  a_cond_never: assert property (cond_in == `COND_NV
    |=> !exec_enable_out)
    else $error("never condition executed");
  a_cond_eq: assert property (cond_in == `COND_EQ
    && !pc_psr_register_in[`PSR_Z] |=> !exec_enable_out)
    else $error("equal condition executed with zero clear");
  a_cop_wait: assert property (cop_offer_out && cop_busy_in
    |-> ##[0:1] stall_out && !pc_load_out)
    else $error("no wait on busy coprocessor");
  // A store to an illegal address is turned into a load in the next cycle.
  a_store_to_load: assert property (store_in && bad_addr
    && data_access_in && !branch_in && !block_later_word_in && !stall_out
    |=> force_load_out)
    else $error("store to illegal address not turned to load");
  // Every vector load closes a spell of entry cycles.
  a_entry_busy: assert property (pc_load_out
    |-> $past(entry_busy_out))
    else $error("vector load without entry cycles");
endmodule // exc_entry_chk

bind exc_entry exc_entry_chk #(.LDM_MAX(LDM_MAX)) u_chk (.*);

// >>> sim/irq_cop_model.sv
// Far-side model: fast and normal interrupt sources and one coprocessor.
// Assumes the bench starts requests by level and feeds back the mode bits.
`timescale 1ns/1ps
`include "exc_defines.vh"
module irq_cop_model #(
  parameter BUSY_CYC = 3
) (
  input wire sys_clk_in,
  input wire rstn_in,
  input wire fiq_go_in,
  input wire irq_go_in,
  input wire cop_cap_in,
  input wire cop_offer_in,
  input wire [1:0] mode_in,
  output wire fiq_n_out,
  output wire irq_n_out,
  output wire cop_accept_out,
  output wire cop_busy_out
);
  reg fiq_q;
  reg [3:0] cnt_q;
  // The fast request is held until fast mode shows; a source that let
  // go sooner could lose its interrupt. The coprocessor counts busy time.
  always @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fiq_q <= 1'b0;
      cnt_q <= 4'h0;
    end else begin
      fiq_q <= fiq_go_in | (fiq_q & (mode_in != `MODE_FIQ));
      cnt_q <= !cop_offer_in ? 4'h0 :
        (cnt_q == BUSY_CYC ? cnt_q : cnt_q + 4'h1);
    end
  end
  // Busy first, then accept, only when the coprocessor is capable.
  assign cop_busy_out = cop_offer_in & cop_cap_in &
    (cnt_q != BUSY_CYC);
  assign cop_accept_out = cop_offer_in & cop_cap_in & (cnt_q == BUSY_CYC);
  assign fiq_n_out = ~fiq_q;
  assign irq_n_out = ~irq_go_in;
endmodule // irq_cop_model

// >>> sim/tb_exc_entry.sv
// Self-checking bench for the exception entry unit.
// Assumes entries are taken at an end_of_instr_in edge in run state.
`timescale 1ns/1ps
`include "exc_defines.vh"
module tb_exc_entry;
  typedef struct packed {
    logic [10:0] f;
    logic [25:0] v;
    logic [1:0] b;
  } row_t;
  logic sys_clk_in = 1'b0, rstn_in = 1'b0, reset_input_in = 1'b0;
  logic abort_input_in = 1'b0, end_of_instr_in = 1'b0, undef_instr_in = 1'b0;
  logic cop_instr_in = 1'b0, software_interrupt_instruction_in = 1'b0;
  logic prefetch_abort_flag_in = 1'b0, data_access_in = 1'b0, store_in = 1'b0;
  logic branch_in = 1'b0, block_later_word_in = 1'b0;
  logic [31:0] pc_psr_register_in = 32'h0, data_addr_in = 32'h1000;
  logic [3:0] cond_in = `COND_AL;
  logic fiq_go = 1'b0, irq_go = 1'b0, cop_cap = 1'b0;
  wire fast_interrupt_request_n_in, irq_request_n_in, cop_accept_in;
  wire cop_busy_in, exec_enable_out, force_load_out, stall_out;
  wire cop_offer_out, entry_busy_out, pc_load_out, link_write_out;
  wire mode_bit_high_out, mode_bit_low_out, int_disable_out, fiq_disable_out;
  wire [25:0] pc_value_out;
  wire [1:0] link_bank_out;
  wire [31:0] link_register_out;
  int fail_count = 0, n_compared = 0, cyc = 0, i, n, n_exp;
  row_t r;
  row_t rows [15];
  logic [8:0] ctab [5];

  irq_cop_model u_far (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .fiq_go_in(fiq_go),
    .irq_go_in(irq_go),
    .cop_cap_in(cop_cap),
    .cop_offer_in(cop_offer_out),
    .mode_in({mode_bit_high_out, mode_bit_low_out}),
    .fiq_n_out(fast_interrupt_request_n_in),
    .irq_n_out(irq_request_n_in),
    .cop_accept_out(cop_accept_in),
    .cop_busy_out(cop_busy_in)
  );
  exc_entry dut (.*);

  // Free-running 25 MHz clock.
  initial begin
    forever #20 sys_clk_in = ~sys_clk_in;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait for the vector load pulse; cnt is edges waited.
  task automatic wait_pl(output int cnt);
    cnt = 0;
    do begin
      @(posedge sys_clk_in);
      #1;
      cnt++;
    end while (pc_load_out !== 1'b1 && cnt < 40);
    if (cnt >= 40) chk(32'h1, 32'h0);
  endtask

  // Retire the instruction: its decode and data levels last one edge, so
  // nothing of it lingers to be taken again after the entry.
  task automatic retire();
    {end_of_instr_in, undef_instr_in, cop_instr_in} <= 3'h0;
    {software_interrupt_instruction_in, prefetch_abort_flag_in} <= 2'h0;
    {abort_input_in, data_access_in, store_in} <= 3'h0;
    {branch_in, block_later_word_in} <= 2'h0;
  endtask

  task automatic idle();
    @(posedge sys_clk_in);
    {undef_instr_in, cop_instr_in, software_interrupt_instruction_in} <= 3'h0;
    {prefetch_abort_flag_in, abort_input_in, data_access_in} <= 3'h0;
    {store_in, branch_in, block_later_word_in, fiq_go, irq_go} <= 5'h0;
    data_addr_in <= 32'h1000;
    cond_in <= `COND_AL;
  endtask

  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // A hang counts as a mismatch and ends the run.
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      finish_test();
    end
  end

  initial begin
    // Flags: I F und swi pab dab adr irq fiq branch later-word.
    rows = '{{11'b00_1000_000_00, `VEC_UNDEF, `MODE_SVC},
      {11'b00_0100_000_00, `VEC_SWI, `MODE_SVC},
      {11'b00_0010_000_00, `VEC_PABORT, `MODE_SVC},
      {11'b00_0001_000_00, `VEC_DABORT, `MODE_SVC},
      {11'b00_0000_100_00, `VEC_ADDREXC, `MODE_SVC},
      {11'b00_0000_010_00, `VEC_IRQ, `MODE_IRQ},
      {11'b00_0000_001_00, `VEC_FIQ, `MODE_FIQ},
      {11'b00_0010_010_00, `VEC_IRQ, `MODE_IRQ},
      {11'b00_0000_011_00, `VEC_FIQ, `MODE_FIQ},
      {11'b10_1000_010_00, `VEC_UNDEF, `MODE_SVC},
      {11'b00_0001_100_00, `VEC_ADDREXC, `MODE_SVC},
      {11'b00_0100_100_10, `VEC_SWI, `MODE_SVC},
      {11'b00_1000_100_01, `VEC_UNDEF, `MODE_SVC},
      {11'b00_0101_000_00, `VEC_DABORT, `MODE_SVC},
      {11'b01_0010_001_00, `VEC_PABORT, `MODE_SVC}};
    ctab = '{{`COND_EQ, 4'h4, 1'b1}, {`COND_EQ, 4'h0, 1'b0},
      {`COND_AL, 4'h0, 1'b1}, {`COND_NV, 4'hF, 1'b0},
      {`COND_MI, 4'h8, 1'b1}};
    repeat (10) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    // Power-up entry, then a pin reset in mid-run and its entry.
    for (i = 0; i < 2; i++) begin
      wait_pl(n);
      chk(pc_value_out, `VEC_RESET);
      chk({link_bank_out, mode_bit_high_out, mode_bit_low_out}, 4'hF);
      chk({int_disable_out, fiq_disable_out}, 2'h3);
      chk(link_register_out, pc_psr_register_in);
      if (i == 0) begin
        @(posedge sys_clk_in);
        reset_input_in <= 1'b1;
        repeat (8) @(posedge sys_clk_in);
        #1;
        chk({stall_out, exec_enable_out}, 2'h2);
        @(posedge sys_clk_in);
        reset_input_in <= 1'b0;
      end
    end
    // Interrupts are raised first so they are synchronised by the edge.
    for (i = 0; i < 15; i++) begin
      r = rows[i];
      @(posedge sys_clk_in);
      pc_psr_register_in <= {4'h4, r.f[10:9], 26'h0000100};
      irq_go <= r.f[3];
      fiq_go <= r.f[2];
      repeat (5) @(posedge sys_clk_in);
      undef_instr_in <= r.f[8];
      software_interrupt_instruction_in <= r.f[7];
      prefetch_abort_flag_in <= r.f[6];
      abort_input_in <= r.f[5];
      data_access_in <= r.f[5] | r.f[4];
      store_in <= r.f[4];
      data_addr_in <= r.f[4] ? 32'hFC000000 : 32'h1000;
      {branch_in, block_later_word_in} <= r.f[1:0];
      end_of_instr_in <= 1'b1;
      @(posedge sys_clk_in);
      retire();
      wait_pl(n);
      // Data aborts and address exceptions take three cycles; an undefined trap adds its offer cycle.
      n_exp = (r.v == `VEC_DABORT || r.v == `VEC_ADDREXC) ? 3 : 2;
      chk(n, n_exp + (r.v == `VEC_UNDEF));
      chk(pc_value_out, r.v);
      chk({link_bank_out, mode_bit_high_out, mode_bit_low_out}, {2{r.b}});
      chk(link_register_out, pc_psr_register_in);
      chk(int_disable_out, 1'b1);
      if (r.b == `MODE_FIQ) chk(fiq_disable_out, 1'b1);
      idle();
    end
    // Data abort with a fast request pending: two entries back to back.
    @(posedge sys_clk_in);
    pc_psr_register_in <= 32'h40000100;
    fiq_go <= 1'b1;
    repeat (5) @(posedge sys_clk_in);
    {abort_input_in, data_access_in, end_of_instr_in} <= 3'h7;
    @(posedge sys_clk_in);
    retire();
    wait_pl(n);
    chk(n, 3);
    chk(pc_value_out, `VEC_DABORT);
    wait_pl(n);
    chk(n, 2);
    chk(pc_value_out, `VEC_FIQ);
    idle();
    // Condition field against the flags in the status word.
    for (i = 0; i < 5; i++) begin
      @(posedge sys_clk_in);
      {cond_in, pc_psr_register_in[31:28]} <= ctab[i][8:1];
      repeat (2) @(posedge sys_clk_in);
      #1;
      chk(exec_enable_out, ctab[i][0]);
    end
    idle();
    // Capable but busy coprocessor: no trap; absent one: trap.
    for (i = 1; i >= 0; i--) begin
      @(posedge sys_clk_in);
      cop_cap <= i[0];
      {cop_instr_in, end_of_instr_in} <= 2'h3;
      @(posedge sys_clk_in);
      retire();
      n = 0;
      repeat (12) begin
        @(posedge sys_clk_in);
        #1;
        if (pc_load_out === 1'b1 && pc_value_out === `VEC_UNDEF) n++;
      end
      chk(n, 1 - i);
      idle();
    end
    finish_test();
  end
endmodule // tb_exc_entry
